// ---- src/vsz_serializer.sv ----
// dual plane video serializer with axi4-lite control
// How it works
// - each refresh fetch loads ten bits per plane
// - blocks shift serially into format steering
// - grey scale: planes in parallel on outputs
// - ored mode: plane bits ored onto both
// - double width: doubled rate, plane0 then plane1
// - interlace: refresh address reused for two lines
// - interlace: even lines plane0, odd plane1
// - each output blanked by its own off bit
// - low four x bits select pixel in block
// - translation yields plane select signal
// - two control bits choose display format
// - off bits: zero enables, reset clears
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module vsz_serializer #(
  parameter int unsigned BLK     = vsz_pkg::BLK_BITS,
  parameter int unsigned DOT_DIV = vsz_pkg::DOT_DIV
) (
  // clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        resetn_i,
  // axi4-lite write address and data
  input  wire logic                        s_axi_awvalid_i,
  output logic                             s_axi_awready_o,
  input  wire logic [vsz_pkg::ADDR_W-1:0]  s_axi_awaddr_i,
  input  wire logic                        s_axi_wvalid_i,
  output logic                             s_axi_wready_o,
  input  wire logic [31:0]                 s_axi_wdata_i,
  input  wire logic [3:0]                  s_axi_wstrb_i,
  // axi4-lite write response
  output logic                             s_axi_bvalid_o,
  input  wire logic                        s_axi_bready_i,
  output logic [1:0]                       s_axi_bresp_o,
  // axi4-lite read
  input  wire logic                        s_axi_arvalid_i,
  output logic                             s_axi_arready_o,
  input  wire logic [vsz_pkg::ADDR_W-1:0]  s_axi_araddr_i,
  output logic                             s_axi_rvalid_o,
  input  wire logic                        s_axi_rready_i,
  output logic [31:0]                      s_axi_rdata_o,
  output logic [1:0]                       s_axi_rresp_o,
  // refresh fetch: plane1 in upper half, plane0 in lower half
  input  wire logic                        blk_valid_i,
  output logic                             blk_ready_o,
  input  wire logic [2*BLK-1:0]            blk_data_i,
  // scan line parity from line timing
  input  wire logic                        scan_odd_i,
  output logic                             refresh_addr_hold_o,
  // x address translation
  input  wire logic [vsz_pkg::XLAT_W-1:0]  xlat_x_i,
  input  wire logic                        xlat_y_odd_i,
  output logic [vsz_pkg::SEL_W-1:0]        pixel_in_block_select_o,
  output logic [vsz_pkg::COL_W-1:0]        pixel_block_column_addr_o,
  output logic                             plane_select_o,
  // ttl video
  output logic                             video0_o,
  output logic                             video1_o
);
  localparam int unsigned DW = (DOT_DIV > 1) ? $clog2(DOT_DIV) : 1;
  localparam logic [4:0]  LEN_ONE = 5'(BLK);
  localparam logic [4:0]  LEN_TWO = 5'(2 * BLK);

  // ==================================================
  // state
  logic [7:0]             ctrl_ff;        // control register
  logic [DW-1:0]          div_ff;         // dot divider
  logic [BLK-1:0]         sh0_ff;         // plane0 shifter
  logic [BLK-1:0]         sh1_ff;         // plane1 shifter
  logic [4:0]             left_ff;        // bits still to emit
  logic                   aw_ff;          // write address held
  logic                   w_ff;           // write data held
  logic [vsz_pkg::ADDR_W-1:0] awaddr_ff;
  logic [31:0]            wdata_ff;
  logic [3:0]             wstrb_ff;
  // combinational
  vsz_pkg::vsz_fmt_t      fmt;            // decoded format
  logic                   fmt_dbl;        // double width active
  logic                   off0;           // output 0 blanked
  logic                   off1;           // output 1 blanked
  logic                   pix_en;         // one pixel step
  logic                   have_blk;       // shifter holds bits
  logic                   active;         // a pixel is available
  logic [BLK-1:0]         src0;
  logic [BLK-1:0]         src1;
  logic [4:0]             src_left;
  logic                   in_p1;          // double width, second half
  logic                   raw0;
  logic                   raw1;
  logic [BLK-1:0]         nxt_sh0;
  logic [BLK-1:0]         nxt_sh1;
  logic [4:0]             nxt_left;
  logic                   nxt_v0;
  logic                   nxt_v1;
  logic                   wr_go;          // both write halves held

  vsz_stream_if #(.W(2 * BLK)) in_s ();
  vsz_stream_if #(.W(2 * BLK)) blk_s ();

  // ==================================================
  // fetch buffer: a late shifter backs up into the fetch port
  assign in_s.valid  = blk_valid_i;
  assign in_s.data   = blk_data_i;
  assign blk_ready_o = in_s.ready;

  vsz_pair_buf #(.W(2 * BLK)) u_buf (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .in_s     (in_s),
    .out_s    (blk_s)
  );

  // ==================================================
  // format decode
  assign fmt     = vsz_pkg::vsz_fmt_t'(ctrl_ff[vsz_pkg::CTRL_FMT_LSB +: 2]);
  assign fmt_dbl = (fmt == vsz_pkg::FMT_DBL_WIDTH);
  assign off0    = ctrl_ff[vsz_pkg::CTRL_OFF0_BIT];
  assign off1    = ctrl_ff[vsz_pkg::CTRL_OFF1_BIT];

  // dot rate: every cycle in double width, else one in DOT_DIV
  assign pix_en = fmt_dbl || (div_ff == DW'(DOT_DIV - 1));

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_ff <= '0;
    end else if (pix_en) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + DW'(1);
    end
  end

  // ==================================================
  // shifter datapath; a new block is taken only once the last is spent
  assign have_blk    = (left_ff != 5'h0);
  assign blk_s.ready = pix_en && !have_blk;

  always_comb begin
    active   = have_blk || blk_s.valid;
    src0     = have_blk ? sh0_ff : blk_s.data[BLK-1:0];
    src1     = have_blk ? sh1_ff : blk_s.data[2*BLK-1:BLK];
    src_left = have_blk ? left_ff : (fmt_dbl ? LEN_TWO : LEN_ONE);
    in_p1    = fmt_dbl && (src_left <= LEN_ONE);
    // double width drains plane0 first, then plane1
    nxt_sh0  = in_p1 ? src0 : (src0 >> 1);
    nxt_sh1  = (fmt_dbl && !in_p1) ? src1 : (src1 >> 1);
    nxt_left = src_left - 5'h1;
    case (fmt)
      vsz_pkg::FMT_DBL_WIDTH: begin
        raw0 = in_p1 ? src1[0] : src0[0];
        raw1 = 1'b0;
      end
      vsz_pkg::FMT_INTERLACE: begin
        raw0 = scan_odd_i ? src1[0] : src0[0];
        raw1 = 1'b0;
      end
      vsz_pkg::FMT_ORED: begin
        raw0 = src0[0] | src1[0];
        raw1 = src0[0] | src1[0];
      end
      default: begin
        raw0 = src0[0];
        raw1 = src1[0];
      end
    endcase
    nxt_v0 = active && raw0 && !off0;
    nxt_v1 = active && raw1 && !off1;
  end

  // shift registers and bit count
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sh0_ff  <= '0;
      sh1_ff  <= '0;
      left_ff <= 5'h0;
    end else if (pix_en && active) begin
      sh0_ff  <= nxt_sh0;
      sh1_ff  <= nxt_sh1;
      left_ff <= nxt_left;
    end
  end

  // video pins; an off bit blanks at once, not at the next pixel
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      video0_o <= 1'b0;
      video1_o <= 1'b0;
    end else if (pix_en) begin
      video0_o <= nxt_v0;
      video1_o <= nxt_v1;
    end else begin
      video0_o <= video0_o && !off0;
      video1_o <= video1_o && !off1;
    end
  end

  // ==================================================
  // refresh line reuse and address translation outputs
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      refresh_addr_hold_o       <= 1'b0;
      pixel_in_block_select_o   <= '0;
      pixel_block_column_addr_o <= '0;
      plane_select_o            <= 1'b0;
    end else begin
      // even line's address is held so the odd line fetches it again
      refresh_addr_hold_o       <= (fmt == vsz_pkg::FMT_INTERLACE) && !scan_odd_i;
      pixel_in_block_select_o   <= xlat_x_i[vsz_pkg::SEL_W-1:0];
      pixel_block_column_addr_o <= xlat_x_i[vsz_pkg::SEL_W +: vsz_pkg::COL_W];
      if (fmt_dbl) begin
        plane_select_o <= xlat_x_i[vsz_pkg::PAGE_BIT];
      end else if (fmt == vsz_pkg::FMT_INTERLACE) begin
        plane_select_o <= xlat_y_odd_i;
      end else begin
        plane_select_o <= 1'b0;
      end
    end
  end

  // ==================================================
  // axi4-lite write: address and data caught in either order
  assign s_axi_awready_o = !aw_ff && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_ff && !s_axi_bvalid_o;
  assign wr_go           = aw_ff && w_ff && !s_axi_bvalid_o;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff  <= 32'h0;
      wstrb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr_i;
      end else if (wr_go) begin
        aw_ff <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end else if (wr_go) begin
        w_ff <= 1'b0;
      end
    end
  end

  // control register and write response
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_ff        <= vsz_pkg::CTRL_RST;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= vsz_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
      if (awaddr_ff[vsz_pkg::ADDR_W-1:2] == vsz_pkg::REG_CTRL_OFS[vsz_pkg::ADDR_W-1:2]) begin
        if (wstrb_ff[0]) begin
          ctrl_ff <= {wdata_ff[7:4], 4'h0};
        end
        s_axi_bresp_o <= vsz_pkg::RESP_OKAY;
      end else if (awaddr_ff[vsz_pkg::ADDR_W-1:2] == vsz_pkg::REG_STAT_OFS[vsz_pkg::ADDR_W-1:2]) begin
        s_axi_bresp_o <= vsz_pkg::RESP_OKAY;  // read-only, write ignored
      end else begin
        s_axi_bresp_o <= vsz_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // axi4-lite read: one cycle from address to data
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0;
      s_axi_rresp_o  <= vsz_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      if (s_axi_araddr_i[vsz_pkg::ADDR_W-1:2] == vsz_pkg::REG_CTRL_OFS[vsz_pkg::ADDR_W-1:2]) begin
        s_axi_rdata_o <= {24'h0, ctrl_ff};
        s_axi_rresp_o <= vsz_pkg::RESP_OKAY;
      end else if (s_axi_araddr_i[vsz_pkg::ADDR_W-1:2] == vsz_pkg::REG_STAT_OFS[vsz_pkg::ADDR_W-1:2]) begin
        s_axi_rdata_o <= {25'h0, left_ff, have_blk, blk_s.valid};
        s_axi_rresp_o <= vsz_pkg::RESP_OKAY;
      end else begin
        s_axi_rdata_o <= 32'h0;
        s_axi_rresp_o <= vsz_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ==================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  AST_LOAD_LEN: assert property (
    blk_s.valid && blk_s.ready && !fmt_dbl |=> left_ff == LEN_ONE - 5'h1)
    else $error("block load did not set nine bits left");
  AST_RELOAD_EMPTY: assert property (
    blk_s.valid && blk_s.ready |-> left_ff == 5'h0)
    else $error("block taken before previous block was spent");
  AST_STEP: assert property (
    pix_en && have_blk |=> left_ff == $past(left_ff) - 5'h1)
    else $error("shifter did not advance one bit");
  AST_GREY: assert property (
    pix_en && active && fmt == vsz_pkg::FMT_GREY && !off0 && !off1
    |=> video0_o == $past(src0[0]) && video1_o == $past(src1[0]))
    else $error("grey scale outputs do not follow planes");
  AST_ORED: assert property (
    pix_en && fmt == vsz_pkg::FMT_ORED && !off0 && !off1 |=> video0_o == video1_o)
    else $error("ored outputs differ");
  AST_DBL: assert property (
    fmt_dbl |-> pix_en ##1 (!video1_o || !fmt_dbl))
    else $error("double width rate or output 1 wrong");
  AST_ILACE: assert property (
    pix_en && active && fmt == vsz_pkg::FMT_INTERLACE && !off0 && scan_odd_i
    |=> video0_o == $past(src1[0]))
    else $error("odd line did not carry plane 1");
  AST_HOLD: assert property (
    fmt == vsz_pkg::FMT_INTERLACE && !scan_odd_i ##1 fmt == vsz_pkg::FMT_INTERLACE
    |-> refresh_addr_hold_o)
    else $error("even line address not held for reuse");
  AST_OFF: assert property (
    off0 ##1 off0 |-> !video0_o)
    else $error("disabled output 0 still drives");
  AST_XSEL: assert property (
    ##1 pixel_in_block_select_o == $past(xlat_x_i[vsz_pkg::SEL_W-1:0]))
    else $error("pixel select does not follow low x bits");
  AST_PLANE: assert property (
    fmt_dbl |=> plane_select_o == $past(xlat_x_i[vsz_pkg::PAGE_BIT]))
    else $error("plane select does not follow x page bit");
  AST_OFF1: assert property (
    off1 ##1 off1 |-> !video1_o)
    else $error("disabled output 1 still drives");
endmodule
`default_nettype wire

// ---- src/vsz_pkg.sv ----
// constants and types shared by the video serializer files
package vsz_pkg;
  // ==================================================
  // pixel blocks
  localparam int unsigned BLK_BITS      = 10;  // pixels per plane per refresh fetch
  localparam int unsigned XLAT_W        = 11;  // translated x address width
  localparam int unsigned SEL_W         = 4;   // pixel-in-block select width
  localparam int unsigned COL_W         = 6;   // block column address width
  localparam int unsigned PAGE_BIT      = 10;  // translated x bit naming the plane
  // ==================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;  // system clock period
  localparam int unsigned DOT_PERIOD_NS = 40;  // normal dot period
  localparam int unsigned DOT_DIV       = (DOT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==================================================
  // register map
  localparam int unsigned ADDR_W        = 4;
  localparam logic [3:0]  REG_CTRL_OFS  = 4'h0;
  localparam logic [3:0]  REG_STAT_OFS  = 4'h4;
  localparam int unsigned CTRL_OFF0_BIT = 4;   // plane0_video_off
  localparam int unsigned CTRL_OFF1_BIT = 5;   // plane1_video_off
  localparam int unsigned CTRL_FMT_LSB  = 6;   // format_sel_low, format_sel_high above it
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // ==================================================
  // display formats, in {format_sel_high, format_sel_low} order
  typedef enum logic [1:0] {
    FMT_DBL_WIDTH,
    FMT_INTERLACE,
    FMT_ORED,
    FMT_GREY
  } vsz_fmt_t;
endpackage

// ---- src/vsz_stream_if.sv ----
// valid/ready word stream between the serializer and its buffer
`timescale 1ns/10ps
`default_nettype none
interface vsz_stream_if #(
  parameter int unsigned W = 20
);
  logic         valid;  // word offered
  logic         ready;  // word accepted
  logic [W-1:0] data;   // word payload
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- src/vsz_pair_buf.sv ----
// two-entry buffer holding fetched pixel blocks
`timescale 1ns/10ps
`default_nettype none
module vsz_pair_buf #(
  parameter int unsigned W = 20
) (
  // clock and reset
  input  wire logic   clock_i,
  input  wire logic   resetn_i,
  // streams
  vsz_stream_if.snk   in_s,
  vsz_stream_if.src   out_s
);
  logic [W-1:0] mem_ff [2];  // storage entries
  logic         wr_ff;       // write pointer
  logic         rd_ff;       // read pointer
  logic [1:0]   cnt_ff;      // occupancy
  logic         push;
  logic         pop;

  // ==================================================
  // handshakes: full and empty are exact, so a stalled reader fills it
  assign in_s.ready  = (cnt_ff != 2'h2);
  assign out_s.valid = (cnt_ff != 2'h0);
  assign out_s.data  = mem_ff[rd_ff];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // storage write, no reset needed on data
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_s.data;
    end
  end

  // pointers and count
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ff  <= 1'b0;
      rd_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      if (push) begin
        wr_ff <= ~wr_ff;
      end
      if (pop) begin
        rd_ff <= ~rd_ff;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 2'h1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/vsz_monitor.sv ----
// video monitor model that captures the two ttl video lines
`timescale 1ns/10ps
`default_nettype none
module vsz_monitor (
  // clock
  input  wire logic clock_i,
  // ttl video from the serializer
  input  wire logic video0_i,
  input  wire logic video1_i
);
  // ==================================================
  // capture
  // a ttl line carries no frame mark, so the first lit pixel starts the capture;
  // each block sent to us must therefore light its first pixel on some line
  task automatic grab(input int n, input int st, output logic [19:0] g0,
                      output logic [19:0] g1);
    int k;
    k = 0;
    g0 = '0;
    g1 = '0;
    @(negedge clock_i);
    while (!(video0_i || video1_i) && k < 400) begin
      @(negedge clock_i);
      k++;
    end
    // one sample per pixel step, taken mid-cycle where the lines are settled
    for (int i = 0; i < n; i++) begin
      g0[i] = video0_i;
      g1[i] = video1_i;
      repeat (st) @(negedge clock_i);
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/vsz_serializer_tb.sv ----
// self-checking bench for the dual plane video serializer
`timescale 1ns/10ps
`default_nettype none
module vsz_serializer_tb;
  // ==================================================
  // stimulus and observed signals
  logic        clock_i = 0, resetn_i = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0]  awaddr = '0, araddr = '0, wstrb = '0;
  logic [31:0] wdata = '0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        blk_valid = 0, blk_ready, scan_odd = 0, y_odd = 0, hold;
  logic [19:0] blk_data = '0;
  logic [10:0] xlat_x = '0;
  logic [3:0]  sel;
  logic [5:0]  col;
  logic        plane, v0, v1;
  int          err_total = 0, cmp_count = 0;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          k;

  always #10 clock_i = ~clock_i;  // 50 MHz

  vsz_serializer dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .blk_valid_i(blk_valid),
    .blk_ready_o(blk_ready), .blk_data_i(blk_data), .scan_odd_i(scan_odd),
    .refresh_addr_hold_o(hold), .xlat_x_i(xlat_x), .xlat_y_odd_i(y_odd),
    .pixel_in_block_select_o(sel), .pixel_block_column_addr_o(col),
    .plane_select_o(plane), .video0_o(v0), .video1_o(v1));

  vsz_monitor mon (.clock_i(clock_i), .video0_i(v0), .video1_i(v1));

  // ==================================================
  // checking and closing
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==================================================
  // axi4-lite master: address and data offered together, response awaited
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd, bd;
    ad = 0;
    wd = 0;
    bd = 0;
    awvalid <= 1;
    awaddr  <= a;
    wvalid  <= 1;
    wdata   <= d;
    wstrb   <= 4'hf;
    bready  <= 1;
    while (!bd) begin
      @(posedge clock_i);
      if (awvalid && awready) begin
        ad = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        wd = 1;
        wvalid <= 0;
      end
      if (bready && bvalid) begin
        bd = 1;
        bready <= 0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
    end
    // let an edge pass so a following call does not re-raise bready in this step
    @(posedge clock_i);
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic rdn;
    rdn = 0;
    arvalid <= 1;
    araddr  <= a;
    rready  <= 1;
    while (!rdn) begin
      @(posedge clock_i);
      if (arvalid && arready) begin
        arvalid <= 0;
      end
      if (rready && rvalid) begin
        rdn = 1;
        rready <= 0;
        d = rdata;
        r = rresp;
      end
    end
    // let an edge pass so a following call does not re-raise rready in this step
    @(posedge clock_i);
  endtask

  // ==================================================
  // fetch stream: n words offered back to back, valid held between them
  task automatic push(input logic [19:0] a, input logic [19:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      blk_valid <= 1;
      blk_data  <= (i == 0) ? a : b;
      @(posedge clock_i);
      while (!blk_ready) @(posedge clock_i);
    end
    blk_valid <= 0;
  endtask

  // one block in one format, expected lines worked out from the format bits
  task automatic run_case(input logic [7:0] c, input logic odd, input logic [9:0] p0,
                          input logic [9:0] p1);
    logic [19:0] e0, e1, g0, g1;
    int n, st;
    axi_wr(vsz_pkg::REG_CTRL_OFS, {24'h0, c}, vsz_pkg::RESP_OKAY);
    scan_odd <= odd;
    n  = 10;
    st = vsz_pkg::DOT_DIV;
    e1 = '0;
    case (c[7:6])
      2'h0: begin
        n  = 20;
        st = 1;
        e0 = {p1, p0};
      end
      2'h1: e0 = odd ? {10'h0, p1} : {10'h0, p0};
      2'h2: begin
        e0 = {10'h0, p0 | p1};
        e1 = e0;
      end
      default: begin
        e0 = {10'h0, p0};
        e1 = {10'h0, p1};
      end
    endcase
    if (c[4]) e0 = '0;
    if (c[5]) e1 = '0;
    push({p1, p0}, 20'h0, 1);
    mon.grab(n, st, g0, g1);
    chk("video0", {12'h0, e0}, {12'h0, g0});
    chk("video1", {12'h0, e1}, {12'h0, g1});
    repeat (60) @(posedge clock_i);
  endtask

  // ==================================================
  // watchdog: the whole run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    test_done();
  end

  // ==================================================
  // main sequence
  initial begin
    logic [19:0] g0, g1;
    repeat (12) @(posedge clock_i);
    resetn_i <= 1;
    @(posedge clock_i);
    axi_rd(vsz_pkg::REG_CTRL_OFS, rd, rs);
    chk("ctrl reset", 32'h0, rd);
    chk("ctrl rresp", {30'h0, vsz_pkg::RESP_OKAY}, {30'h0, rs});
    axi_rd(4'h8, rd, rs);
    chk("unmapped rresp", {30'h0, vsz_pkg::RESP_SLVERR}, {30'h0, rs});
    axi_wr(4'h8, 32'hff, vsz_pkg::RESP_SLVERR);
    // translation in double width: plane from x bit 10
    xlat_x <= 11'h5a7;
    repeat (3) @(posedge clock_i);
    chk("pixel select", 32'h7, {28'h0, sel});
    chk("block column", 32'h1a, {26'h0, col});
    chk("plane select", 32'h1, {31'h0, plane});
    run_case(8'h00, 1'b0, 10'h2b5, 10'h1c3);
    run_case(8'h40, 1'b0, 10'h2b5, 10'h1c3);
    run_case(8'h40, 1'b1, 10'h2b4, 10'h1c3);
    run_case(8'h80, 1'b0, 10'h0a5, 10'h252);
    run_case(8'hc0, 1'b0, 10'h2b5, 10'h1c3);
    run_case(8'hd0, 1'b0, 10'h2b5, 10'h1c3);
    run_case(8'he0, 1'b0, 10'h2b5, 10'h1c3);
    axi_rd(vsz_pkg::REG_CTRL_OFS, rd, rs);
    chk("ctrl readback", 32'he0, rd);
    // two blocks back to back: second only after the first is fully out
    axi_wr(vsz_pkg::REG_CTRL_OFS, 32'hc0, vsz_pkg::RESP_OKAY);
    push(20'h70e4b, 20'h394cd, 2);
    mon.grab(20, vsz_pkg::DOT_DIV, g0, g1);
    chk("video0 pair", 32'h3364b, {12'h0, g0});
    chk("video1 pair", 32'h395c3, {12'h0, g1});
    // interlace: address reuse on even lines, plane from y lsb
    axi_wr(vsz_pkg::REG_CTRL_OFS, 32'h40, vsz_pkg::RESP_OKAY);
    scan_odd <= 0;
    y_odd    <= 1;
    repeat (3) @(posedge clock_i);
    chk("addr hold even", 32'h1, {31'h0, hold});
    chk("plane select y", 32'h1, {31'h0, plane});
    scan_odd <= 1;
    y_odd    <= 0;
    repeat (3) @(posedge clock_i);
    chk("addr hold odd", 32'h0, {31'h0, hold});
    chk("plane select y0", 32'h0, {31'h0, plane});
    // fill the buffer with both outputs off until it refuses, then drain
    axi_wr(vsz_pkg::REG_CTRL_OFS, 32'hf0, vsz_pkg::RESP_OKAY);
    blk_valid <= 1;
    blk_data  <= 20'h3ff;
    k = 0;
    @(negedge clock_i);
    while (blk_ready === 1'b1 && k < 8) begin
      @(negedge clock_i);
      k++;
    end
    chk("buffer refuses", 32'h0, {31'h0, blk_ready});
    chk("video off", 32'h0, {30'h0, v1, v0});
    // the refused word stays offered until the buffer takes it
    @(posedge clock_i);
    while (!blk_ready) @(posedge clock_i);
    blk_valid <= 0;
    repeat (200) @(posedge clock_i);
    axi_rd(vsz_pkg::REG_STAT_OFS, rd, rs);
    chk("status drained", 32'h0, rd);
    test_done();
  end
endmodule
`default_nettype wire
